// *** src/dpdc_pkg.sv ***
/*
 package for the daisy-port discard counters: register offsets, field widths, reset values.
 assumes an axi4-lite master with 32-bit data; printed offsets are register indices.
*/
// Function
// - keep 8-bit read-only upper-port response discard counter at index 0x267
// - keep 8-bit read-only lower-port response discard counter at index 0x268
// - keep 8-bit read-only upper-port command discard counter at index 0x269
// - reading 0x267 snapshots all upper-port counters, then clears their running counts
// - reading lower command register snapshots all lower-port counters, then clears them
// - discards caused by frame integrity faults never advance any counter
// - keep lower-port command discard counter at 0x266; its read snapshots lower port
package dpdc_pkg;
   localparam int unsigned CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam int unsigned ADDR_W = 12;
   // printed offsets are not all multiples of four: they are indices
   localparam logic [9:0] IDX_LOWER_CMD = 10'h266;
   localparam logic [9:0] IDX_UPPER_RSP = 10'h267;
   localparam logic [9:0] IDX_LOWER_RSP = 10'h268;
   localparam logic [9:0] IDX_UPPER_CMD = 10'h269;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h270;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h271;
   localparam int unsigned NUM_CNT = 4;
   localparam logic [NUM_CNT-1:0] IRQ_RST = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// *** src/dpdc_counter.sv ***
/*
 one saturating running discard counter with a snapshot register.
 assumes count and snap come from logic on the same clock.
*/
`timescale 1ns/1ns
module dpdc_counter (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // events
   input wire logic count,
   input wire logic snap,
   // state
   output logic [dpdc_pkg::CNT_W-1:0] snap_val,
   output logic saturated,
   output logic [dpdc_pkg::CNT_W-1:0] run_val
);
   logic [dpdc_pkg::CNT_W-1:0] run_r, run_nxt, snap_r, snap_nxt;

   always_comb begin
      run_nxt = run_r;
      snap_nxt = snap_r;
      if (snap) begin
         // snapshot then clear; an event in the same cycle starts the new interval
         snap_nxt = run_r;
         run_nxt = count ? 8'h01 : dpdc_pkg::CNT_RST;
      end else if (count && run_r != dpdc_pkg::CNT_MAX) begin
         run_nxt = run_r + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_r <= dpdc_pkg::CNT_RST;
         snap_r <= dpdc_pkg::CNT_RST;
      end else begin
         run_r <= run_nxt;
         snap_r <= snap_nxt;
      end
   end

   assign snap_val = snap_r;
   assign saturated = (run_r == dpdc_pkg::CNT_MAX);
   assign run_val = run_r;
endmodule

// *** src/dpdc_top.sv ***
/*
 discard statistics for the upper and lower daisy-chain ports behind an axi4-lite slave.
 assumes the frame decoders give one-cycle discard pulses with an integrity flag, on aclk.
*/
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module dpdc_top (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [dpdc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [dpdc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // discard events: 0 upper rsp, 1 lower rsp, 2 upper cmd, 3 lower cmd
   input wire logic [3:0] frame_discard,
   input wire logic [3:0] frame_integrity_fault,
   // interrupt
   output logic irq
);
   localparam int unsigned N = dpdc_pkg::NUM_CNT;

   logic [N-1:0] count, snap, sat;
   logic [dpdc_pkg::CNT_W-1:0] snap_val [N];
   // running values; a trigger register answers with the count captured at its read
   logic [dpdc_pkg::CNT_W-1:0] run_val [N];
   logic snap_upper, snap_lower;
   logic [9:0] ar_idx, aw_idx;

   // write channel state
   logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
   logic [9:0] aw_idx_r, aw_idx_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   // read channel state
   logic rvalid_r, rvalid_nxt, arready_r, arready_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   // interrupt state
   logic [N-1:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt;
   logic irq_r, irq_nxt;
   logic ar_take, aw_take, w_take, wr_do;

   assign count = frame_discard & ~frame_integrity_fault;

   assign ar_take = s_axi_arvalid && arready_r;
   assign ar_idx = s_axi_araddr[11:2];
   assign snap_upper = ar_take && ar_idx == dpdc_pkg::IDX_UPPER_RSP;
   assign snap_lower = ar_take && ar_idx == dpdc_pkg::IDX_LOWER_CMD;
   assign snap = {snap_lower, snap_upper, snap_lower, snap_upper};

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cnt
         dpdc_counter u_cnt (
            .aclk(aclk),
            .aresetn(aresetn),
            .count(count[g]),
            .snap(snap[g]),
            .snap_val(snap_val[g]),
            .saturated(sat[g]),
            .run_val(run_val[g])
         );
      end
   endgenerate

   assign aw_take = s_axi_awvalid && !aw_got_r && !bvalid_r;
   assign w_take = s_axi_wvalid && !w_got_r && !bvalid_r;
   assign aw_idx = aw_take ? s_axi_awaddr[11:2] : aw_idx_r;

   always_comb begin
      aw_got_nxt = aw_got_r | aw_take;
      w_got_nxt = w_got_r | w_take;
      aw_idx_nxt = aw_idx;
      wdata_nxt = w_take ? s_axi_wdata : wdata_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      wr_do = 1'b0;
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (aw_got_nxt && w_got_nxt && !bvalid_r) begin
         wr_do = 1'b1;
         aw_got_nxt = 1'b0;
         w_got_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         case (aw_idx)
            dpdc_pkg::IDX_IRQ_STATUS, dpdc_pkg::IDX_IRQ_MASK: bresp_nxt = dpdc_pkg::RESP_OKAY;
            dpdc_pkg::IDX_LOWER_CMD, dpdc_pkg::IDX_UPPER_RSP,
            dpdc_pkg::IDX_LOWER_RSP, dpdc_pkg::IDX_UPPER_CMD: bresp_nxt = dpdc_pkg::RESP_SLVERR;
            default: bresp_nxt = dpdc_pkg::RESP_DECERR;
         endcase
      end
   end

   always_comb begin
      logic [31:0] wv;
      wv = w_take ? s_axi_wdata : wdata_r;
      irq_mask_nxt = irq_mask_r;
      // event set wins over a write-one-to-clear
      irq_stat_nxt = irq_stat_r;
      if (wr_do && aw_idx == dpdc_pkg::IDX_IRQ_STATUS) begin
         irq_stat_nxt = irq_stat_r & ~wv[N-1:0];
      end
      if (wr_do && aw_idx == dpdc_pkg::IDX_IRQ_MASK) begin
         irq_mask_nxt = wv[N-1:0];
      end
      irq_stat_nxt = irq_stat_nxt | (count & ~sat);
      irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
   end

   always_comb begin
      rvalid_nxt = rvalid_r;
      arready_nxt = arready_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
         arready_nxt = 1'b1;
      end
      if (ar_take) begin
         arready_nxt = 1'b0;
         rvalid_nxt = 1'b1;
         rresp_nxt = dpdc_pkg::RESP_OKAY;
         // a snapshot read returns the values just captured
         case (ar_idx)
            dpdc_pkg::IDX_UPPER_RSP: rdata_nxt = {24'h0, run_val[0]};
            dpdc_pkg::IDX_LOWER_RSP: rdata_nxt = {24'h0, snap_val[1]};
            dpdc_pkg::IDX_UPPER_CMD: rdata_nxt = {24'h0, snap_val[2]};
            dpdc_pkg::IDX_LOWER_CMD: rdata_nxt = {24'h0, run_val[3]};
            dpdc_pkg::IDX_IRQ_STATUS: rdata_nxt = {28'h0, irq_stat_r};
            dpdc_pkg::IDX_IRQ_MASK: rdata_nxt = {28'h0, irq_mask_r};
            default: begin
               rdata_nxt = 32'h0;
               rresp_nxt = dpdc_pkg::RESP_DECERR;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         aw_idx_r <= 10'h000;
         wdata_r <= 32'h0;
         bvalid_r <= 1'b0;
         bresp_r <= dpdc_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
         rdata_r <= 32'h0;
         rresp_r <= dpdc_pkg::RESP_OKAY;
         irq_stat_r <= dpdc_pkg::IRQ_RST;
         irq_mask_r <= dpdc_pkg::IRQ_RST;
         irq_r <= 1'b0;
      end else begin
         aw_got_r <= aw_got_nxt;
         w_got_r <= w_got_nxt;
         aw_idx_r <= aw_idx_nxt;
         wdata_r <= wdata_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         arready_r <= arready_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
         irq_stat_r <= irq_stat_nxt;
         irq_mask_r <= irq_mask_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ready flags are registered; wready/awready track whether each half is held
   logic awready_r, wready_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
      end else begin
         awready_r <= !aw_got_nxt && !bvalid_nxt;
         wready_r <= !w_got_nxt && !bvalid_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign irq = irq_r;
endmodule

// *** dv/dpdc_props.sv ***
/* assertions on the discard counter ports.
 bound to dpdc_top; sees its ports only. */
`timescale 1ns/1ns
module dpdc_props (
   // clock, reset, bus, events
   input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire logic [dpdc_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr,
   input wire logic [1:0] s_axi_bresp, s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [3:0] frame_discard, frame_integrity_fault
);
   logic [7:0] up_r, up_nxt;
   // reference running count of the upper response discards
   always_comb begin
      up_nxt = s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == dpdc_pkg::IDX_UPPER_RSP ? 8'h00 : up_r;
      if (frame_discard[0] && !frame_integrity_fault[0] && up_nxt != 8'hff) up_nxt = up_nxt + 8'h01;
   end
   always_ff @(posedge aclk) begin
      up_r <= aresetn ? up_nxt : 8'h00;
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
   sequence s_wr_take; s_axi_awvalid && s_axi_awready; endsequence
   property p_live_upper; s_rd_take ##0 s_axi_araddr[11:2] == dpdc_pkg::IDX_UPPER_RSP
      |=> s_axi_rdata == {24'h0, $past(up_r)}; endproperty
   a_live_upper: assert property (p_live_upper) else $error("live count");
   property p_rd_answer; s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer");
   property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read hold");
   property p_width; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
   a_width: assert property (p_width) else $error("width");
   property p_ro_write; s_wr_take ##0 s_axi_awaddr[11:2] inside {[10'h266:10'h269]}
      |-> ##[1:20] s_axi_bvalid && s_axi_bresp == dpdc_pkg::RESP_SLVERR; endproperty
   a_ro_write: assert property (p_ro_write) else $error("write taken");
   property p_unmapped; s_rd_take ##0 s_axi_araddr[11:2] > dpdc_pkg::IDX_IRQ_MASK
      |=> s_axi_rresp == dpdc_pkg::RESP_DECERR && s_axi_rdata == 32'h0; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped");
   property p_wr_answer; s_wr_take and (s_axi_wvalid && s_axi_wready) |=> s_axi_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer");
   property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_ar_block: assert property (p_ar_block) else $error("read overlap");
endmodule
bind dpdc_top dpdc_props dpdc_props_inst (.*);

// *** dv/dpdc_peer.sv ***
/* neighbour devices on both daisy ports: random discard pulses.
 assumes the bench clock; quiet while run is low. */
`timescale 1ns/1ns
module dpdc_peer (
   input wire logic aclk,
   input wire logic run,
   input wire logic faults,
   output logic [3:0] frame_discard,
   output logic [3:0] frame_integrity_fault
);
   integer seed = 32'hda63;
   initial frame_discard = 4'h0;
   initial frame_integrity_fault = 4'h0;
   // corrupt frames only when the bench asks for them
   always @(posedge aclk) begin
      frame_discard <= run ? 4'($random(seed)) : 4'h0;
      frame_integrity_fault <= run && faults ? 4'($random(seed)) : 4'h0;
   end
endmodule

// *** dv/dpdc_top_test.sv ***
/* self-checking bench: axi4-lite master, neighbour model, expected tallies.
 assumes the checker binds itself to the design. */
`timescale 1ns/1ns
module dpdc_top_test;
   logic aclk = 0, aresetn = 0, run = 0, faults = 0, s_axi_bready = 1, irq;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf, frame_discard, frame_integrity_fault;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   int n_tests = 0, n_mismatch = 0, cyc = 0, cnt[4] = '{0, 0, 0, 0};
   initial forever #50 aclk = ~aclk;
   dpdc_top dpdc_top_inst (.*);
   dpdc_peer dpdc_peer_inst (.*);
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
      for (int i = 0; i < 4; i++) cnt[i] += int'(frame_discard[i] && !frame_integrity_fault[i]);
   end
   function logic [31:0] sat(int c);
      return c > 255 ? 32'hff : 32'(c);
   endfunction
   task wrap_up();
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task chk(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task rd(logic [9:0] idx);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      // late rready lets the slave hold its answer
      repeat (2) @(posedge aclk);
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task wr(logic [9:0] idx, logic [31:0] v);
      logic a, w;
      a = 0;
      w = 0;
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(a && w)) begin
         @(posedge aclk);
         a = a | (s_axi_awready === 1'b1);
         w = w | (s_axi_wready === 1'b1);
         s_axi_awvalid <= !a;
         s_axi_wvalid <= !w;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
   endtask
   task traffic(int n, logic f);
      run <= 1'b1;
      faults <= f;
      repeat (n) @(posedge aclk);
      run <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask
   task snaps(string s);
      rd(dpdc_pkg::IDX_UPPER_RSP);
      chk(d, sat(cnt[0]));
      rd(dpdc_pkg::IDX_UPPER_CMD);
      chk(d, sat(cnt[2]));
      rd(dpdc_pkg::IDX_LOWER_CMD);
      chk(d, sat(cnt[3]));
      rd(dpdc_pkg::IDX_LOWER_RSP);
      chk(d, sat(cnt[1]));
      cnt = '{0, 0, 0, 0};
      $display("%s done", s);
   endtask
   task irqc(logic b);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'(b));
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      snaps("reset");
      traffic(60, 1'b1);
      snaps("faults");
      snaps("cleared");
      traffic(1300, 1'b0);
      snaps("saturate");
      wr(dpdc_pkg::IDX_UPPER_CMD, 32'h5a);
      chk(32'(r), 32'(dpdc_pkg::RESP_SLVERR));
      rd(10'h3ff);
      chk(32'(r), 32'(dpdc_pkg::RESP_DECERR));
      wr(dpdc_pkg::IDX_IRQ_STATUS, 32'hf);
      wr(dpdc_pkg::IDX_IRQ_MASK, 32'hf);
      irqc(1'b0);
      traffic(30, 1'b0);
      irqc(1'b1);
      wr(dpdc_pkg::IDX_IRQ_MASK, 32'h0);
      irqc(1'b0);
      wr(dpdc_pkg::IDX_IRQ_MASK, 32'hf);
      irqc(1'b1);
      wr(dpdc_pkg::IDX_IRQ_STATUS, 32'hf);
      irqc(1'b0);
      $display("irq done");
      wrap_up();
   end
endmodule
